//--- verilog/alu_pkg.sv
// holds constants, field layouts and carrier types of the add/sub/multiply unit
// assumes a 32-bit integer pipeline and an apb register port on pclk
package alu_pkg;
  // ****************************************
  // widths and instruction fields
  // ****************************************
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PADDR_W = 8;
  localparam int unsigned OPX_HI = 24;
  localparam int unsigned OPX_LO = 19;
  localparam int unsigned IMM_SEL_BIT = 13;
  localparam int unsigned IMM_HI = 12;
  localparam int unsigned TAG_HI = 1;
  localparam int unsigned SIGN_BIT = 31;
  // ****************************************
  // opcode extension values
  // ****************************************
  localparam logic [5:0] OP_ADD = 6'h00;
  localparam logic [5:0] OP_ADDCC = 6'h10;
  localparam logic [5:0] OP_ADDX = 6'h08;
  localparam logic [5:0] OP_ADDXCC = 6'h18;
  localparam logic [5:0] OP_SUB = 6'h04;
  localparam logic [5:0] OP_SUBCC = 6'h14;
  localparam logic [5:0] OP_SUBX = 6'h0c;
  localparam logic [5:0] OP_SUBXCC = 6'h1c;
  localparam logic [5:0] OP_TSUM = 6'h20;
  localparam logic [5:0] OP_TSUM_TRAP = 6'h22;
  localparam logic [5:0] OP_TDIFF = 6'h21;
  localparam logic [5:0] OP_TDIFF_TRAP = 6'h23;
  localparam logic [5:0] OP_MSTEP = 6'h24;
  localparam logic [5:0] OP_UMUL = 6'h0a;
  localparam logic [5:0] OP_SMUL = 6'h0b;
  localparam logic [5:0] OP_UMULCC = 6'h1a;
  localparam logic [5:0] OP_SMULCC = 6'h1b;
  localparam int unsigned OP_CC_BIT = 4;
  localparam int unsigned OP_SIGNED_BIT = 0;
  // ****************************************
  // register map and reset values
  // ****************************************
  localparam logic [7:0] ADDR_UPPER = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [31:0] UPPER_RST = 32'h0;
  localparam logic [31:0] ZERO_WORD = 32'h0;
  // ****************************************
  // carrier types
  // ****************************************
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } flags_type;
  localparam flags_type FLAGS_RST = 4'h0;
  typedef struct packed {
    logic [31:0] instr;
    logic [31:0] src1;
    logic [31:0] src2;
  } issue_req_type;
  typedef struct packed {
    logic valid;
    logic wr_en;
    logic trap;
    logic [31:0] result;
  } resp_type;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_MUL = 2'b10} seq_state_type;
  // sign-extend the 13-bit immediate
  function automatic logic [31:0] sign_ext13(input logic [12:0] imm);
    sign_ext13 = {{19{imm[IMM_HI]}}, imm};
  endfunction
  // second operand: register or immediate, chosen by the select bit
  function automatic logic [31:0] second_operand(input logic [31:0] instr,
                                                 input logic [31:0] src2);
    second_operand = instr[IMM_SEL_BIT] ? sign_ext13(instr[IMM_HI:0]) : src2;
  endfunction
endpackage

//--- verilog/sum_unit.sv
// holds the shared 32-bit adder/subtractor with carry and overflow
// assumes operands are stable within the cycle; purely combinational
`timescale 1ns/1ps
module sum_unit (
  input logic [alu_pkg::DATA_W-1:0] op_a, // first operand
  input logic [alu_pkg::DATA_W-1:0] op_b, // second operand
  input logic sub, // high: a - b - cin
  input logic cin, // carry or borrow in
  output logic [alu_pkg::DATA_W-1:0] sum,
  output logic carry, // carry out, or borrow for subtraction
  output logic ovf // signed overflow
);
  import alu_pkg::*;
  logic [DATA_W:0] wide; // 33-bit raw sum
  logic [DATA_W-1:0] b_eff; // inverted for subtraction
  // subtraction as a + ~b + ~borrow, so one adder serves both
  always_comb begin
    b_eff = sub ? ~op_b : op_b;
    wide = {1'b0, op_a} + {1'b0, b_eff} + {{DATA_W{1'b0}}, sub ^ cin};
    sum = wide[DATA_W-1:0];
    carry = sub ? ~wide[DATA_W] : wide[DATA_W];
    if (sub) begin
      ovf = (op_a[SIGN_BIT] != op_b[SIGN_BIT]) && (sum[SIGN_BIT] != op_a[SIGN_BIT]);
    end else begin
      ovf = (op_a[SIGN_BIT] == op_b[SIGN_BIT]) && (sum[SIGN_BIT] != op_a[SIGN_BIT]);
    end
  end
endmodule // sum_unit

//--- verilog/product_unit.sv
// holds the registered 32x32 multiplier, signed or unsigned
// assumes start is a one-cycle pulse; product is ready one edge later
`timescale 1ns/1ps
module product_unit (
  input logic pclk,
  input logic presetn,
  input logic start, // one-cycle launch
  input logic signed_mode, // two's complement operands
  input logic [alu_pkg::DATA_W-1:0] op_a,
  input logic [alu_pkg::DATA_W-1:0] op_b,
  output logic done, // one-cycle pulse with product
  output logic [2*alu_pkg::DATA_W-1:0] prod
);
  import alu_pkg::*;
  typedef struct packed {
    logic done;
    logic [2*DATA_W-1:0] prod;
  } prod_state_type;
  prod_state_type st_ff; // all state
  prod_state_type nxt_st; // next state
  logic signed [DATA_W:0] ext_a; // one extra bit carries the sign
  logic signed [DATA_W:0] ext_b;
  logic signed [2*DATA_W+1:0] full; // 66-bit product
  // ****************************************
  // next state
  // ****************************************
  // sign bit is zero for unsigned, so one signed multiplier covers both
  always_comb begin
    ext_a = $signed({op_a[SIGN_BIT] & signed_mode, op_a});
    ext_b = $signed({op_b[SIGN_BIT] & signed_mode, op_b});
    full = ext_a * ext_b;
    nxt_st = st_ff;
    nxt_st.done = start;
    if (start) begin
      nxt_st.prod = full[2*DATA_W-1:0];
    end
  end
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign done = st_ff.done;
  assign prod = st_ff.prod;
endmodule // product_unit

//--- verilog/alu_top.sv
// holds the integer add, subtract, tagged, multiply-step and multiply unit
// assumes the pipeline presents one instruction with operands per accepted cycle
// and that apb reaches the upper product word and the condition flags
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module alu_top (
  input logic pclk,
  input logic presetn,
  // instruction issue
  input logic issue_valid,
  input alu_pkg::issue_req_type issue_req,
  output logic issue_ready,
  // result to the pipeline
  output alu_pkg::resp_type resp,
  output logic [alu_pkg::DATA_W-1:0] upper_word,
  output alu_pkg::flags_type flags,
  // apb slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [alu_pkg::PADDR_W-1:0] paddr,
  input logic [alu_pkg::DATA_W-1:0] pwdata,
  output logic [alu_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr
);
  import alu_pkg::*;
  // ****************************************
  // state and wires
  // ****************************************
  typedef struct packed {
    seq_state_type seq; // sequencer
    logic ready; // may accept an instruction
    resp_type resp; // last answer
    logic [DATA_W-1:0] upper; // upper product word
    flags_type flags; // condition flags
    logic [5:0] pend_op; // multiply in flight
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } top_state_type;
  top_state_type st_ff; // all state
  top_state_type nxt_st; // next state
  logic issue_acc; // instruction taken this cycle
  logic [5:0] op; // opcode extension field
  logic [DATA_W-1:0] op2; // register or immediate
  logic [DATA_W-1:0] add_a; // adder inputs
  logic [DATA_W-1:0] add_b;
  logic add_sub;
  logic add_cin;
  logic [DATA_W-1:0] add_sum; // adder outputs
  logic add_carry;
  logic add_ovf;
  flags_type arith_flags; // flags from the adder
  logic tag_fault;
  logic mul_start;
  logic mul_done;
  logic [2*DATA_W-1:0] mul_prod;
  logic apb_wr; // apb write completes
  logic apb_setup; // apb setup phase

  assign issue_acc = issue_valid && st_ff.ready;
  assign op = issue_req.instr[OPX_HI:OPX_LO];
  // select and immediate fields
  // operand format
  assign op2 = second_operand(issue_req.instr, issue_req.src2);
  assign mul_start = issue_acc && (op == OP_UMUL || op == OP_SMUL ||
                                   op == OP_UMULCC || op == OP_SMULCC);
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && st_ff.pready && pwrite;

  // ****************************************
  // adder operand steering
  // ****************************************
  // one adder is shared by every non-multiply operation
  always_comb begin
    // first source plus register or immediate
    add_a = issue_req.src1;
    add_b = op2;
    add_sub = 1'b0;
    add_cin = 1'b0;
    case (op)
      OP_ADDX, OP_ADDXCC: begin
        add_cin = st_ff.flags.c;
      end
      OP_SUB, OP_SUBCC, OP_TDIFF, OP_TDIFF_TRAP: begin
        add_sub = 1'b1;
      end
      OP_SUBX, OP_SUBXCC: begin
        add_sub = 1'b1;
        add_cin = st_ff.flags.c;
      end
      OP_MSTEP: begin
        // shift with n xor v on top
        add_a = {st_ff.flags.n ^ st_ff.flags.v, issue_req.src1[DATA_W-1:1]};
        add_b = st_ff.upper[0] ? op2 : ZERO_WORD;
      end
      default: begin
        add_sub = 1'b0;
      end
    endcase
  end

  sum_unit u_sum (
    .op_a(add_a),
    .op_b(add_b),
    .sub(add_sub),
    .cin(add_cin),
    .sum(add_sum),
    .carry(add_carry),
    .ovf(add_ovf)
  );

  // signedness from the low opcode bit
  product_unit u_prod (
    .pclk(pclk),
    .presetn(presetn),
    .start(mul_start),
    .signed_mode(op[OP_SIGNED_BIT]),
    .op_a(issue_req.src1),
    .op_b(op2),
    .done(mul_done),
    .prod(mul_prod)
  );

  always_comb begin
    arith_flags.n = add_sum[SIGN_BIT];
    arith_flags.z = (add_sum == ZERO_WORD);
    arith_flags.v = add_ovf;
    arith_flags.c = add_carry;
  end
  assign tag_fault = (|issue_req.src1[TAG_HI:0]) || (|op2[TAG_HI:0]) || add_ovf;

  // ****************************************
  // next state
  // ****************************************
  // apb writes are applied first so that an instruction in the same
  // cycle overrides them; the pipeline view must stay coherent
  always_comb begin
    nxt_st = st_ff;
    nxt_st.resp.valid = 1'b0;
    nxt_st.resp.trap = 1'b0;
    // apb answers one cycle after setup, no wait states
    nxt_st.pready = apb_setup;
    nxt_st.pslverr = 1'b0;
    if (apb_setup) begin
      case (paddr)
        ADDR_UPPER: nxt_st.prdata = st_ff.upper;
        ADDR_FLAGS: nxt_st.prdata = {{(DATA_W-4){1'b0}}, st_ff.flags};
        ADDR_STATUS: nxt_st.prdata = {{(DATA_W-1){1'b0}}, ~st_ff.ready};
        default: begin
          // unmapped: zero data and error
          nxt_st.prdata = ZERO_WORD;
          nxt_st.pslverr = 1'b1;
        end
      endcase
    end
    if (apb_wr) begin
      if (paddr == ADDR_UPPER) begin
        nxt_st.upper = pwdata;
      end
      if (paddr == ADDR_FLAGS) begin
        nxt_st.flags = pwdata[3:0];
      end
    end
    unique case (st_ff.seq)
      ST_IDLE: begin
        if (issue_acc) begin
          nxt_st.resp.valid = 1'b1;
          nxt_st.resp.wr_en = 1'b1;
          nxt_st.resp.result = add_sum;
          case (op)
            OP_ADD, OP_ADDX, OP_SUB, OP_SUBX: begin
              nxt_st.resp.wr_en = 1'b1;
            end
            OP_ADDCC, OP_ADDXCC, OP_SUBCC, OP_SUBXCC: begin
              nxt_st.flags = arith_flags;
            end
            OP_TSUM, OP_TDIFF: begin
              nxt_st.flags = arith_flags;
              nxt_st.flags.v = tag_fault;
            end
            OP_TSUM_TRAP, OP_TDIFF_TRAP: begin
              if (tag_fault) begin
                nxt_st.resp.trap = 1'b1;
                nxt_st.resp.wr_en = 1'b0;
                nxt_st.flags = st_ff.flags;
              end else begin
                nxt_st.flags = arith_flags;
                nxt_st.flags.v = 1'b0;
              end
            end
            OP_MSTEP: begin
              // step over source and upper word
              nxt_st.flags = arith_flags;
              nxt_st.upper = {issue_req.src1[0], st_ff.upper[DATA_W-1:1]};
            end
            OP_UMUL, OP_SMUL, OP_UMULCC, OP_SMULCC: begin
              // answer comes when the product is registered
              nxt_st.resp.valid = 1'b0;
              nxt_st.seq = ST_MUL;
              nxt_st.ready = 1'b0;
              nxt_st.pend_op = op;
            end
            default: begin
              // unknown opcode: answer, no write
              nxt_st.resp.wr_en = 1'b0;
            end
          endcase
        end
      end
      ST_MUL: begin
        if (mul_done) begin
          nxt_st.resp.valid = 1'b1;
          nxt_st.resp.wr_en = 1'b1;
          nxt_st.resp.result = mul_prod[DATA_W-1:0];
          nxt_st.upper = mul_prod[2*DATA_W-1:DATA_W];
          if (st_ff.pend_op[OP_CC_BIT]) begin
            // n and z from low word
            nxt_st.flags.n = mul_prod[SIGN_BIT];
            nxt_st.flags.z = (mul_prod[DATA_W-1:0] == ZERO_WORD);
            nxt_st.flags.v = 1'b0;
            nxt_st.flags.c = 1'b0;
          end
          nxt_st.seq = ST_IDLE;
          nxt_st.ready = 1'b1;
        end
      end
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff.seq <= ST_IDLE;
      st_ff.ready <= 1'b1;
      st_ff.resp <= '0;
      st_ff.upper <= UPPER_RST;
      st_ff.flags <= FLAGS_RST;
      st_ff.pend_op <= OP_ADD;
      st_ff.prdata <= ZERO_WORD;
      st_ff.pready <= 1'b0;
      st_ff.pslverr <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign issue_ready = st_ff.ready;
  assign resp = st_ff.resp;
  assign upper_word = st_ff.upper;
  assign flags = st_ff.flags;
  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence mul_issue_s;
    issue_acc && (op == OP_UMUL);
  endsequence
  sequence mul_answer_s;
    ##2 resp.valid && resp.wr_en;
  endsequence

  plain_sum_a: assert property (
    issue_acc && op == OP_ADD |=> resp.valid && resp.wr_en &&
      resp.result == $past(issue_req.src1) + $past(op2) && $stable(flags))
    else $error("plain sum result or flags wrong");
  carry_sum_a: assert property (
    issue_acc && op == OP_ADDX |=> resp.result ==
      $past(issue_req.src1) + $past(op2) + {31'h0, $past(flags.c)})
    else $error("carry sum ignores carry flag");
  borrow_diff_a: assert property (
    issue_acc && op == OP_SUBXCC |=> resp.result ==
      $past(issue_req.src1) - $past(op2) - {31'h0, $past(flags.c)})
    else $error("borrow difference wrong");
  diff_overflow_a: assert property (
    issue_acc && op == OP_SUBCC |=> flags.v == (($past(issue_req.src1[31]) !=
      $past(op2[31])) && (resp.result[31] != $past(issue_req.src1[31]))))
    else $error("difference overflow flag wrong");
  tag_trap_a: assert property (
    issue_acc && op == OP_TSUM_TRAP && tag_fault |=> resp.trap &&
      !resp.wr_en && $stable(flags))
    else $error("tag trap changed state");
  tag_flag_a: assert property (
    issue_acc && op == OP_TSUM |=> !resp.trap && resp.wr_en &&
      flags.v == $past(tag_fault))
    else $error("tagged overflow flag wrong");
  step_upper_a: assert property (
    issue_acc && op == OP_MSTEP |=> upper_word ==
      {$past(issue_req.src1[0]), $past(upper_word[31:1])})
    else $error("step upper word shift wrong");
  umul_split_a: assert property (
    mul_issue_s |-> mul_answer_s ##0 ({upper_word, resp.result} ==
      {32'h0, $past(issue_req.src1, 2)} * {32'h0, $past(op2, 2)}) &&
      $stable(flags))
    else $error("unsigned product wrong");
  mul_flags_a: assert property (
    issue_acc && op == OP_SMULCC |-> ##2 resp.valid && !flags.v && !flags.c &&
      flags.z == (resp.result == 32'h0) && flags.n == resp.result[31])
    else $error("multiply flags wrong");
endmodule // alu_top

//--- verification/pipe_model.sv
// pipeline issue model: offers one decoded instruction with operands
// assumes the unit samples issue_valid and issue_ready on the rising edge of pclk
`timescale 1ns/1ps
module pipe_model (
  input wire logic pclk,
  input wire logic issue_ready,
  output logic issue_valid,
  output alu_pkg::issue_req_type issue_req
);
  import alu_pkg::*;
  // ****************************************
  // idle state
  // ****************************************
  initial begin
    issue_valid = 1'b0;
    issue_req = '0;
  end
  // ****************************************
  // offer one instruction, hold until taken
  // ****************************************
  // format fields packed
  task automatic send(input logic [31:0] instr, input logic [31:0] a, input logic [31:0] b);
    @(posedge pclk);
    issue_valid <= 1'b1;
    issue_req <= {instr, a, b};
    // ready is registered: its value before the edge is the one the unit takes
    do @(posedge pclk); while (issue_ready !== 1'b1);
    issue_valid <= 1'b0;
    // released operands become a changed pattern, so stale reuse shows
    issue_req <= ~{instr, a, b};
  endtask
endmodule // pipe_model

//--- verification/alu_top_tb.sv
// self-checking bench for the add, subtract, tagged, step and multiply unit
// assumes a 100 MHz pclk, apb register map from alu_pkg, pipe_model as issuer
`timescale 1ns/1ps
module alu_top_tb;
  import alu_pkg::*;
  logic pclk, presetn, issue_valid, issue_ready, psel, penable, pwrite, pready, pslverr, e;
  issue_req_type issue_req; // offered instruction
  resp_type resp; // answer to the pipeline
  flags_type flags, fm, fo; // seen, preset and expected flags
  logic [31:0] upper_word, pwdata, prdata, d, ym, yo, rx, a, b, ins;
  logic [7:0] paddr;
  logic we, tr; // expected write and trap
  int error_cnt, samples_checked, cyc;
  logic [5:0] ops [18] = '{OP_ADD, OP_ADDCC, OP_ADDX, OP_ADDXCC, OP_SUB, OP_SUBCC, OP_SUBX,
    OP_SUBXCC, OP_TSUM, OP_TSUM_TRAP, OP_TDIFF, OP_TDIFF_TRAP, OP_MSTEP, OP_UMUL, OP_SMUL,
    OP_UMULCC, OP_SMULCC, 6'h01};
  alu_top alu_top_i (.pclk(pclk), .presetn(presetn), .issue_valid(issue_valid),
    .issue_req(issue_req), .issue_ready(issue_ready), .resp(resp), .upper_word(upper_word),
    .flags(flags), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  pipe_model pipe_model_i (.pclk(pclk), .issue_ready(issue_ready),
    .issue_valid(issue_valid), .issue_req(issue_req));
  // ****************************************
  // clock and hang guard
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ceiling well above the roughly 6k cycles the tests need
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      print_verdict();
    end
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one apb transfer; request held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // sampled at the rising edge, before the slave updates its outputs
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // expected answer of one instruction
  function automatic void model(input logic [31:0] i, x, s2, input flags_type f,
      input logic [31:0] y, output logic [31:0] r, output logic w, t,
      output flags_type fr, output logic [31:0] yr);
    logic [5:0] op;
    logic [31:0] c, sh;
    logic [32:0] s;
    logic [63:0] p;
    logic sb, ci, ov, tg;
    op = i[24:19];
    c = i[13] ? {{19{i[12]}}, i[12:0]} : s2;
    fr = f;
    yr = y;
    w = 1'b1;
    t = 1'b0;
    r = '0;
    if (op == 6'h24) begin
      sh = {f.n ^ f.v, x[31:1]};
      c = y[0] ? c : 32'h0;
      s = {1'b0, sh} + {1'b0, c};
      r = s[31:0];
      fr = {r[31], r == 32'h0, sh[31] == c[31] && r[31] != sh[31], s[32]};
      yr = {x[0], y[31:1]};
    end else if (op[3:1] == 3'b101 && !op[5]) begin
      p = op[0] ? {{32{x[31]}}, x} * {{32{c[31]}}, c} : {32'h0, x} * {32'h0, c};
      r = p[31:0];
      yr = p[63:32];
      if (op[4]) fr = {r[31], r == 32'h0, 2'b00};
    end else if ((!op[5] && op[1:0] == 2'b00) || op[5:2] == 4'b1000) begin
      sb = op[5] ? op[0] : op[2];
      ci = !op[5] && op[3] && f.c;
      s = sb ? {1'b0, x} - {1'b0, c} - ci : {1'b0, x} + {1'b0, c} + ci;
      r = s[31:0];
      ov = sb ? x[31] != c[31] && r[31] != x[31] : x[31] == c[31] && r[31] != x[31];
      tg = (|x[1:0]) || (|c[1:0]) || ov;
      if (op[5] || op[4]) fr = {r[31], r == 32'h0, op[5] ? tg : ov, s[32]};
      if (op[5] && op[1] && tg) begin
        w = 1'b0;
        t = 1'b1;
        fr = f;
      end
    end else w = 1'b0;
  endfunction
  // preset flags and upper word, issue, then compare the answer
  task automatic run_op(input logic [31:0] i, input logic [31:0] x, input logic [31:0] y);
    int n;
    logic ml; // product in flight
    apb(1'b1, ADDR_FLAGS, {28'h0, fm}, d, e);
    apb(1'b1, ADDR_UPPER, ym, d, e);
    model(i, x, y, fm, ym, rx, we, tr, fo, yo);
    pipe_model_i.send(i, x, y);
    ml = (i[22:20] == 3'b101) && !i[24];
    n = 0;
    do begin
      @(negedge pclk);
      n++;
      // busy only while a product is in flight
      if (n == 1) check(issue_ready, !ml);
    end while (resp.valid !== 1'b1 && n < 6);
    check(n, ml ? 2 : 1);
    check(resp.wr_en, we);
    check(resp.trap, tr);
    if (we) check(resp.result, rx);
    check(flags, fo);
    check(upper_word, yo);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    error_cnt = 0;
    samples_checked = 0;
    cyc = 0;
    void'($urandom(32'haf3bfccd));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // registers after reset, unmapped and read-only places
    apb(1'b0, ADDR_UPPER, 32'h0, d, e);
    check(d, UPPER_RST);
    apb(1'b0, ADDR_FLAGS, 32'h0, d, e);
    check(d, ZERO_WORD);
    apb(1'b1, 8'h0c, 32'h5a5a5a5a, d, e);
    check(e, 1'b1);
    apb(1'b0, 8'h0c, 32'h0, d, e);
    check({e, d}, {1'b1, ZERO_WORD});
    apb(1'b1, ADDR_STATUS, 32'hffffffff, d, e);
    apb(1'b0, ADDR_STATUS, 32'h0, d, e);
    check(d, ZERO_WORD);
    $display("register access test done");
    // every opcode, random operands, tag-clean and overflow corners
    for (int k = 0; k < 40; k++) begin
      foreach (ops[j]) begin
        ins = $urandom;
        ins[24:19] = ops[j];
        a = $urandom;
        b = $urandom;
        if (k[0]) begin
          a = (a >> 3) & ~32'h3;
          b = (b >> 3) & ~32'h3;
          ins[1:0] = 2'b00;
        end
        if (k == 2) begin
          a = 32'h7ffffffc;
          b = 32'h4;
          ins[13] = 1'b0;
        end
        fm = 4'($urandom);
        ym = $urandom;
        run_op(ins, a, b);
      end
    end
    $display("instruction test done");
    print_verdict();
  end
endmodule // alu_top_tb
